// *** design/utopia_tx_pkg.sv ***
package utopia_tx_pkg;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_SYS_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_TX_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_TX_IDLE   = 8'h08;
   localparam logic [7:0] ADDR_TX_ENABLE = 8'h0C;
   localparam logic [7:0] ADDR_TX_STATUS = 8'h10;

   // ----------------------------------------------------------------
   // system control fields
   // ----------------------------------------------------------------
   localparam int SYS_TX_ENGINE_EN  = 29;
   localparam int SYS_RX_ENGINE_EN  = 28;
   localparam int SYS_PIN_DISABLE   = 27;
   localparam int SYS_LOOPBACK_SEL  = 26;
   localparam int SYS_TX_MOD_RESET  = 25;
   localparam int SYS_RX_MOD_RESET  = 24;

   // ----------------------------------------------------------------
   // transmit config fields
   // ----------------------------------------------------------------
   localparam int CFG_ROLE          = 30;
   localparam int CFG_SINGLE        = 29;
   localparam int CFG_OCTET         = 28;
   localparam int CFG_PAR_EN        = 27;
   localparam int CFG_PAR_EVEN      = 26;
   localparam int CFG_HEC_EN        = 25;
   localparam int CFG_COSET         = 24;
   localparam int CFG_LEN_LSB       = 16;
   localparam int CFG_RANGE_LSB     = 8;
   localparam int CFG_SADDR_LSB     = 0;

   // ----------------------------------------------------------------
   // transmit enable fields and idle pattern layout
   // ----------------------------------------------------------------
   localparam int EN_IDLE_GFC       = 31;
   localparam int EN_IDLE_PTI       = 30;
   localparam int EN_IDLE_CLP       = 29;
   localparam logic [31:0] IDLE_GFC_BITS = 32'hF000_0000;
   localparam logic [31:0] IDLE_PTI_BITS = 32'h0000_000E;
   localparam logic [31:0] IDLE_CLP_BITS = 32'h0000_0001;

   // ----------------------------------------------------------------
   // writable masks and reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] SYS_MASK      = 32'h3F00_0000;
   localparam logic [31:0] TXCFG_MASK    = 32'h7F7F_1F1F;
   localparam logic [31:0] TXEN_MASK     = 32'hE000_0000;
   localparam logic [31:0] IDLE_MASK     = 32'hFFFF_FFFF;
   localparam logic [31:0] SYS_RESET     = 32'h0800_0000;
   localparam logic [31:0] TXCFG_RESET   = 32'h2035_0000;
   localparam logic [31:0] TXEN_RESET    = 32'h0000_0000;
   localparam logic [31:0] IDLE_RESET    = 32'h0000_0000;

   // ----------------------------------------------------------------
   // cell format and timing
   // ----------------------------------------------------------------
   localparam logic [6:0] HDR_LAST_IDX  = 7'h03;
   localparam logic [6:0] HEC_IDX       = 7'h04;
   localparam logic [7:0] HEC_POLY      = 8'h07;
   localparam logic [7:0] HEC_COSET     = 8'h55;
   localparam logic [6:0] POLL_SETTLE   = 7'h04;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_POLL = 3'b010,
      ST_SEND = 3'b100
   } tx_state_t;

endpackage

// *** design/utopia_tx_cell_port.sv ***
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
module utopia_tx_cell_port (
   input  wire logic       clk_sys,             // system clock
   input  wire logic       rst_b,               // async reset, active low
   input  wire logic [7:0] paddr,               // apb address
   input  wire logic       psel,                // apb select
   input  wire logic       penable,             // apb enable
   input  wire logic       pwrite,              // apb write
   input  wire logic [31:0] pwdata,             // apb write data
   input  wire logic [3:0] pstrb,               // apb byte strobes
   output logic [31:0]     prdata,              // apb read data
   output logic            pready,              // apb ready
   output logic            pslverr,             // apb error
   input  wire logic [7:0] cell_data,           // cell byte from source
   input  wire logic       cell_valid,          // cell byte valid
   output logic            cell_ready,          // cell byte taken
   output logic            cell_idle,           // header matched idle pattern
   output logic            cell_done,           // last byte of cell sent
   output logic [7:0]      utx_data,            // bus data
   output logic            utx_soc,             // start of cell
   output logic [4:0]      utx_addr,            // polled address
   output logic            transmit_parity_pin, // bus parity
   input  wire logic       utx_enb_b_i,         // enable pin in, slave role
   output logic            utx_enb_b_o,         // enable pin out, master role
   output logic            utx_enb_oe_b,        // enable pin drive, low drives
   input  wire logic       utx_clav_i,          // cell available in, master
   output logic            utx_clav_o,          // cell available out, slave
   output logic            utx_clav_oe_b,       // clav pin drive, low drives
   input  wire logic [4:0] utx_addr_i,          // address in, slave role
   output logic            receive_engine_run,  // receive state machine on
   output logic            receive_module_reset, // receive side held in reset
   output logic            loopback_active,     // loopback in force
   output logic            interface_pins_off   // interface forced inactive
);
   import utopia_tx_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] sys;
      logic [31:0] txcfg;
      logic [31:0] idle;
      logic [31:0] txen;
      logic [31:0] rdata;
      logic [2:0]  clav_s;
      logic [2:0]  enb_s;
      logic [14:0] addr_s;
      logic        clav_f;
      logic        enb_f;
      logic [4:0]  addr_f;
      tx_state_t   state;
      logic [4:0]  poll_addr;
      logic [6:0]  cnt;
      logic [7:0]  crc;
      logic [23:0] hdr;
      logic [7:0]  data;
      logic        soc;
      logic        enb_b;
      logic        par;
      logic        clav_o;
      logic        idle_pulse;
      logic        done_pulse;
      logic        last_idle;
   } st_t;

   st_t  s_q;
   st_t  s_d;
   logic rst_m;
   logic rst_s;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge_wr(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r & mask;
   endfunction

   function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] b);
      logic [7:0] c;
      c = crc ^ b;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ HEC_POLY) : (c << 1);
      end
      return c;
   endfunction

   function automatic logic filt(input logic old, input logic s2, input logic s3);
      return (s2 == s3) ? s3 : old;
   endfunction

   function automatic logic reg_mapped(input logic [7:0] a);
      return (a == ADDR_SYS_CTRL) || (a == ADDR_TX_CONFIG) || (a == ADDR_TX_IDLE) ||
             (a == ADDR_TX_ENABLE) || (a == ADDR_TX_STATUS);
   endfunction

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_m <= 1'b0;
         rst_s <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_s <= rst_m;
      end
   end

   // ----------------------------------------------------------------
   // decoded controls
   // ----------------------------------------------------------------
   logic       pin_off;
   logic       tx_rst;
   logic       run;
   logic       slave;
   logic       single;
   logic       octet;
   logic [6:0] cell_len;
   logic [4:0] poll_range;
   logic [4:0] slave_addr;
   logic       addr_ok;
   logic       slave_ok;
   logic       master_ok;
   logic       can_go;
   logic       go;
   logic [7:0] out_byte;
   logic [31:0] hdr_full;
   logic [31:0] cmp_mask;
   logic       wr_en;

   assign pin_off    = s_q.sys[SYS_PIN_DISABLE];
   assign tx_rst     = s_q.sys[SYS_TX_MOD_RESET];
   assign run        = s_q.sys[SYS_TX_ENGINE_EN] & ~pin_off & ~tx_rst;
   assign slave      = s_q.txcfg[CFG_ROLE];
   assign single     = s_q.txcfg[CFG_SINGLE];
   assign octet      = s_q.txcfg[CFG_OCTET] & single;
   assign cell_len   = s_q.txcfg[CFG_LEN_LSB +: 7];
   assign poll_range = s_q.txcfg[CFG_RANGE_LSB +: 5];
   assign slave_addr = s_q.txcfg[CFG_SADDR_LSB +: 5];
   assign addr_ok    = single | (s_q.addr_f == slave_addr);
   assign slave_ok   = ~s_q.enb_f & addr_ok;
   assign master_ok  = ~octet | s_q.clav_f;
   assign can_go     = (s_q.state == ST_SEND) & run & (slave ? slave_ok : master_ok);
   assign go         = can_go & cell_valid;

   // ----------------------------------------------------------------
   // header check and idle comparison
   // ----------------------------------------------------------------
   assign out_byte   = (s_q.cnt == HEC_IDX && s_q.txcfg[CFG_HEC_EN]) ?
                       (s_q.crc ^ (s_q.txcfg[CFG_COSET] ? HEC_COSET : 8'h00)) :
                       cell_data;
   assign hdr_full   = {s_q.hdr, cell_data};
   assign cmp_mask   = ~((s_q.txen[EN_IDLE_GFC] ? 32'h0000_0000 : IDLE_GFC_BITS) |
                         (s_q.txen[EN_IDLE_PTI] ? 32'h0000_0000 : IDLE_PTI_BITS) |
                         (s_q.txen[EN_IDLE_CLP] ? 32'h0000_0000 : IDLE_CLP_BITS));
   assign wr_en      = psel & penable & pwrite;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.idle_pulse = 1'b0;
      s_d.done_pulse = 1'b0;

      // ----------------------------------------------------------------
      // pin inputs: three flops, change accepted when stages two and three agree
      // ----------------------------------------------------------------
      s_d.clav_s = {s_q.clav_s[1:0], utx_clav_i};
      s_d.enb_s  = {s_q.enb_s[1:0], utx_enb_b_i};
      s_d.addr_s = {s_q.addr_s[9:0], utx_addr_i};
      s_d.clav_f = filt(s_q.clav_f, s_q.clav_s[1], s_q.clav_s[2]);
      s_d.enb_f  = filt(s_q.enb_f, s_q.enb_s[1], s_q.enb_s[2]);
      for (int i = 0; i < 5; i++) begin
         s_d.addr_f[i] = filt(s_q.addr_f[i], s_q.addr_s[5 + i], s_q.addr_s[10 + i]);
      end

      // register read data captured in setup phase; reserved bits masked
      if (psel && !penable) begin
         unique case (paddr)
            ADDR_SYS_CTRL:  s_d.rdata = s_q.sys & SYS_MASK;
            ADDR_TX_CONFIG: s_d.rdata = s_q.txcfg & TXCFG_MASK;
            ADDR_TX_IDLE:   s_d.rdata = s_q.idle;
            ADDR_TX_ENABLE: s_d.rdata = s_q.txen & TXEN_MASK;
            ADDR_TX_STATUS: s_d.rdata = {21'h00_0000, s_q.last_idle, s_q.poll_addr, 2'b00, s_q.state};
            default:        s_d.rdata = 32'h0000_0000;
         endcase
      end

      if (wr_en) begin
         unique case (paddr)
            ADDR_SYS_CTRL:  s_d.sys   = merge_wr(s_q.sys, pwdata, pstrb, SYS_MASK);
            ADDR_TX_CONFIG: s_d.txcfg = merge_wr(s_q.txcfg, pwdata, pstrb, TXCFG_MASK);
            ADDR_TX_IDLE:   s_d.idle  = merge_wr(s_q.idle, pwdata, pstrb, IDLE_MASK);
            ADDR_TX_ENABLE: s_d.txen  = merge_wr(s_q.txen, pwdata, pstrb, TXEN_MASK);
            default:        s_d.sys   = s_q.sys;
         endcase
      end

      // ----------------------------------------------------------------
      // transmit state machine
      // ----------------------------------------------------------------
      unique case (s_q.state)
         ST_IDLE: begin
            s_d.enb_b = 1'b1;
            s_d.soc   = 1'b0;
            s_d.cnt   = 7'h00;
            s_d.crc   = 8'h00;
            if (run) begin
               if (slave || single) begin
                  s_d.poll_addr = 5'h00;
                  s_d.state     = ST_SEND;
               end else begin
                  s_d.state = ST_POLL;
               end
            end
         end
         ST_POLL: begin
            // hold address until clav from that address has passed the synchroniser
            if (s_q.cnt == POLL_SETTLE) begin
               s_d.cnt = 7'h00;
               if (s_q.clav_f) begin
                  s_d.state = ST_SEND;
               end else if (s_q.poll_addr == poll_range) begin
                  s_d.poll_addr = 5'h00;
               end else begin
                  s_d.poll_addr = s_q.poll_addr + 5'h01;
               end
            end else begin
               s_d.cnt = s_q.cnt + 7'h01;
            end
         end
         ST_SEND: begin
            s_d.enb_b = ~go;
            s_d.soc   = go & (s_q.cnt == 7'h00);
            if (go) begin
               s_d.data = out_byte;
               s_d.par  = s_q.txcfg[CFG_PAR_EN] &
                          (s_q.txcfg[CFG_PAR_EVEN] ? ^out_byte : ~^out_byte);
               s_d.cnt  = s_q.cnt + 7'h01;
               if (s_q.cnt <= HDR_LAST_IDX) begin
                  s_d.crc = crc8_step(s_q.crc, cell_data);
                  s_d.hdr = hdr_full[23:0];
               end
               if (s_q.cnt == HDR_LAST_IDX) begin
                  s_d.last_idle  = ((hdr_full ^ s_q.idle) & cmp_mask) == 32'h0000_0000;
                  s_d.idle_pulse = s_d.last_idle;
               end
               if (s_q.cnt == cell_len - 7'h01) begin
                  s_d.done_pulse = 1'b1;
                  s_d.state      = ST_IDLE;
               end
            end
         end
      endcase

      // slave signals cell available when addressed and data is waiting
      s_d.clav_o = slave & run & (s_q.state == ST_SEND) & cell_valid & addr_ok;

      // ----------------------------------------------------------------
      // engine disabled or pins forced off: abort to a quiet state
      // ----------------------------------------------------------------
      if (!run) begin
         s_d.state = ST_IDLE;
         s_d.enb_b = 1'b1;
         s_d.soc   = 1'b0;
      end

      // ----------------------------------------------------------------
      // transmit module reset restores every transmit register
      // ----------------------------------------------------------------
      if (tx_rst) begin
         s_d.txcfg     = TXCFG_RESET;
         s_d.idle      = IDLE_RESET;
         s_d.txen      = TXEN_RESET;
         s_d.poll_addr = 5'h00;
         s_d.data      = 8'h00;
         s_d.par       = 1'b0;
         s_d.last_idle = 1'b0;
         s_d.cnt       = 7'h00;
         s_d.crc       = 8'h00;
         s_d.hdr       = 24'h00_0000;
         s_d.soc       = 1'b0;
         s_d.enb_b     = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_s) begin
      if (!rst_s) begin
         s_q           <= '0;
         s_q.sys       <= SYS_RESET;
         s_q.txcfg     <= TXCFG_RESET;
         s_q.idle      <= IDLE_RESET;
         s_q.txen      <= TXEN_RESET;
         s_q.clav_s    <= 3'b000;
         s_q.enb_s     <= 3'b111;
         s_q.enb_f     <= 1'b1;
         s_q.enb_b     <= 1'b1;
         s_q.state     <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // register bus outputs
   // ----------------------------------------------------------------
   // zero wait states; read data was captured in the setup cycle
   assign prdata  = s_q.rdata;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~reg_mapped(paddr);

   // ----------------------------------------------------------------
   // cell source outputs
   // ----------------------------------------------------------------
   assign cell_ready = can_go;
   assign cell_idle  = s_q.idle_pulse;
   assign cell_done  = s_q.done_pulse;

   // ----------------------------------------------------------------
   // bus pins
   // ----------------------------------------------------------------
   // pin gating only; configuration stays as written
   assign utx_data            = pin_off ? 8'h00 : s_q.data;
   assign utx_soc             = ~pin_off & s_q.soc;
   assign utx_addr            = (pin_off | slave) ? 5'h00 : s_q.poll_addr;
   assign transmit_parity_pin = ~pin_off & s_q.par;
   assign utx_enb_b_o         = pin_off | slave | s_q.enb_b;
   assign utx_enb_oe_b        = pin_off | slave;
   assign utx_clav_o          = ~pin_off & s_q.clav_o;
   assign utx_clav_oe_b       = pin_off | ~slave;

   // ----------------------------------------------------------------
   // receive side and status
   // ----------------------------------------------------------------
   // receive logic lives elsewhere; only its controls leave here
   assign receive_engine_run   = s_q.sys[SYS_RX_ENGINE_EN] & ~s_q.sys[SYS_RX_MOD_RESET] & ~pin_off;
   assign receive_module_reset = s_q.sys[SYS_RX_MOD_RESET];
   assign loopback_active      = ~s_q.sys[SYS_LOOPBACK_SEL] & single;
   assign interface_pins_off   = pin_off;

endmodule

// *** dv/utopia_tx_cell_port_monitor.sv ***
`timescale 1ns/1ps
module utopia_tx_port_checker (
   input wire logic       clk_sys,            // clock
   input wire logic       rst_b,              // reset
   input wire logic       psel,               // apb select
   input wire logic       penable,            // apb enable
   input wire logic       pready,             // apb ready
   input wire logic       pslverr,            // apb error
   input wire logic       cell_valid,         // source valid
   input wire logic       cell_ready,         // byte taken
   input wire logic       cell_idle,          // idle match
   input wire logic       cell_done,          // cell end
   input wire logic [7:0] utx_data,           // bus data
   input wire logic       utx_soc,            // start of cell
   input wire logic       utx_enb_b_o,        // enable out
   input wire logic       utx_enb_oe_b,       // enable drive
   input wire logic       utx_clav_oe_b,      // clav drive
   input wire logic       interface_pins_off  // pins forced off
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   wire logic take = cell_valid && cell_ready;
   a_pins_noready: assert property (interface_pins_off |-> !cell_ready)
      else $error("byte taken while pins off");
   a_pins_nodrive: assert property (interface_pins_off |-> utx_enb_oe_b && utx_clav_oe_b && utx_enb_b_o)
      else $error("pin driven while pins off");
   a_take_enb: assert property (take |=> !utx_enb_b_o)
      else $error("taken byte not on bus");
   a_enb_cause: assert property (!take |=> utx_enb_b_o)
      else $error("enable low without byte");
   a_data_hold: assert property (!take |=> $stable(utx_data))
      else $error("bus data moved without byte");
   a_soc_enb: assert property (utx_soc |-> !utx_enb_b_o)
      else $error("start of cell without transfer");
   a_done_cause: assert property (cell_done |-> $past(take) ##1 !cell_done)
      else $error("cell end without last byte");
   a_idle_pulse: assert property (cell_idle |=> !cell_idle)
      else $error("idle flag longer than one cycle");
   a_apb_nowait: assert property (psel && penable |-> pready)
      else $error("apb wait state");
   a_err_phase: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   c_cell_start: cover property (take && utx_soc);
   c_cell_idle: cover property (cell_idle);
   c_cell_done: cover property (cell_done);
   c_apb_err: cover property (pslverr);
endmodule
bind utopia_tx_cell_port utopia_tx_port_checker chk_i (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .cell_valid(cell_valid), .cell_ready(cell_ready),
   .cell_idle(cell_idle), .cell_done(cell_done), .utx_data(utx_data), .utx_soc(utx_soc),
   .utx_enb_b_o(utx_enb_b_o), .utx_enb_oe_b(utx_enb_oe_b), .utx_clav_oe_b(utx_clav_oe_b),
   .interface_pins_off(interface_pins_off));

// *** dv/utopia_phy_model.sv ***
`timescale 1ns/1ps
module utopia_phy_model (
   input  wire logic       clk_sys,  // clock
   input  wire logic [7:0] utx_data, // bus data
   input  wire logic       utx_soc,  // start of cell
   input  wire logic       par_pin,  // bus parity
   input  wire logic       enb_b,    // enable from master
   output logic            clav,     // cell available
   output logic            enb_b_i,  // enable in, idle high
   output logic [4:0]      addr_i    // address in, unused
);
   logic [9:0] got[$];
   initial begin
      clav = 1'b1;
      enb_b_i = 1'b1;
      addr_i = 5'h1f;
   end
   // capture each transferred byte mid-cycle
   always @(negedge clk_sys) begin
      if (enb_b === 1'b0) got.push_back({utx_soc, par_pin, utx_data});
   end
endmodule

// *** dv/test_utopia_tx_cell_port.sv ***
`timescale 1ns/1ps
module test_utopia_tx_cell_port;
   import utopia_tx_pkg::*;
   logic        clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cell_valid = 1'b0;
   logic [7:0]  paddr = 8'h00, cell_data = 8'h00, utx_data;
   logic [3:0]  pstrb = 4'hf;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, xs = 32'hcf82_9693, pat, hdr;
   logic        pready, pslverr, cell_ready, cell_idle, cell_done, utx_soc, par_pin, err;
   logic        enb_b_o, enb_oe_b, clav_i, clav_o, clav_oe_b, enb_b_i, rx_run, rx_rst, loop_on, pins_off;
   logic [4:0]  utx_addr, addr_i;
   logic        par_en, even, hec, coset;
   logic [9:0]  exp_q[$];
   logic [31:0] flips[4] = '{32'h0000_0000, 32'h1000_0000, 32'h0000_0001, 32'h0000_0002};
   int          mismatches = 0, checks_done = 0, idle_n = 0, done_n = 0;
   always #2.5 clk_sys = ~clk_sys;
   always @(negedge clk_sys) begin
      if (cell_idle === 1'b1) idle_n++;
      if (cell_done === 1'b1) done_n++;
   end
   utopia_tx_cell_port dut (.clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cell_data(cell_data), .cell_valid(cell_valid), .cell_ready(cell_ready), .cell_idle(cell_idle),
      .cell_done(cell_done), .utx_data(utx_data), .utx_soc(utx_soc), .utx_addr(utx_addr),
      .transmit_parity_pin(par_pin), .utx_enb_b_i(enb_b_i), .utx_enb_b_o(enb_b_o), .utx_enb_oe_b(enb_oe_b),
      .utx_clav_i(clav_i), .utx_clav_o(clav_o), .utx_clav_oe_b(clav_oe_b), .utx_addr_i(addr_i),
      .receive_engine_run(rx_run), .receive_module_reset(rx_rst), .loopback_active(loop_on),
      .interface_pins_off(pins_off));
   utopia_phy_model phy (.clk_sys(clk_sys), .utx_data(utx_data), .utx_soc(utx_soc), .par_pin(par_pin),
      .enb_b(enb_b_o), .clav(clav_i), .enb_b_i(enb_b_i), .addr_i(addr_i));
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [7:0] crc8(input logic [31:0] h);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? HEC_POLY : 8'h00);
      return c;
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      @(posedge clk_sys);
      while (s !== 1'b1 && n < 200) begin
         @(posedge clk_sys);
         n++;
      end
      if (s !== 1'b1) begin
         mismatches++;
         tally_and_finish();
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      wait_hi(pready);
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic send_cell(input logic [31:0] h, input int len);
      logic [7:0] b, e;
      for (int i = 0; i < len; i++) begin
         xs = xorshift(xs);
         b = (i < 4) ? h[31-8*i -: 8] : xs[7:0];
         e = (i == 4 && hec) ? crc8(h) ^ (coset ? HEC_COSET : 8'h00) : b;
         exp_q.push_back({i == 0, par_en & (even ? ^e : ~^e), e});
         cell_valid <= 1'b1;
         cell_data <= b;
         wait_hi(cell_ready);
      end
      cell_valid <= 1'b0;
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("pins_off", 1, pins_off);
      apb(0, ADDR_SYS_CTRL, 0);
      chk("sys_reset", SYS_RESET, rd);
      apb(0, ADDR_TX_CONFIG, 0);
      chk("cfg_reset", TXCFG_RESET, rd);
      apb(0, 8'h14, 0);
      chk("unmapped", 1, {rd[30:0] | rd[31], err});
      apb(1, ADDR_TX_CONFIG, 32'hffff_ffff);
      apb(0, ADDR_TX_CONFIG, 0);
      chk("cfg_rsvd", TXCFG_MASK, rd);
      apb(1, ADDR_SYS_CTRL, 32'hffff_ffff);
      apb(0, ADDR_SYS_CTRL, 0);
      chk("sys_rsvd", SYS_MASK, rd);
      apb(0, ADDR_TX_CONFIG, 0);
      chk("tx_mod_reset", TXCFG_RESET, rd);
      $display("test registers done");
      apb(1, ADDR_SYS_CTRL, 32'h1100_0000);
      chk("rx_flags", 3'b011, {rx_run, rx_rst, loop_on});
      cell_valid <= 1'b1;
      repeat (10) begin
         @(negedge clk_sys);
         chk("engine_off", 0, cell_ready);
      end
      @(posedge clk_sys);
      cell_valid <= 1'b0;
      apb(1, ADDR_SYS_CTRL, 32'h3400_0000);
      chk("pins_on", 3'b001, {pins_off, enb_oe_b, loop_on | rx_run});
      for (int k = 0; k < 4; k++) begin
         {par_en, even, coset, hec} = {k != 0, k[0], k[1], k != 3};
         xs = xorshift(xs);
         pat = xs;
         hdr = pat ^ flips[k];
         apb(1, ADDR_TX_CONFIG, {2'b00, 1'b1, 1'b0, par_en, even, hec, coset, 1'b0, 7'(52 + 4 * k), 16'h0000});
         apb(1, ADDR_TX_IDLE, pat);
         apb(1, ADDR_TX_ENABLE, {k != 1, 1'b1, k != 2, 29'h0000_0000});
         idle_n = 0;
         done_n = 0;
         send_cell(hdr, 52 + 4 * k);
         repeat (6) @(posedge clk_sys);
         chk("byte_count", exp_q.size(), phy.got.size());
         while (exp_q.size() > 0 && phy.got.size() > 0)
            chk("bus_byte", exp_q.pop_front(), phy.got.pop_front());
         exp_q.delete();
         phy.got.delete();
         chk("idle_flag", k != 3, idle_n);
         chk("cell_done", 1, done_n);
         $display("test cell %0d done", k);
      end
      apb(1, ADDR_SYS_CTRL, 32'h1400_0000);
      apb(1, ADDR_TX_CONFIG, 32'h0035_0200);
      apb(1, ADDR_SYS_CTRL, 32'h3400_0000);
      repeat (8) @(posedge clk_sys);
      apb(0, ADDR_TX_STATUS, 0);
      chk("poll_status", 32'h0000_0004, rd);
      $display("test poll done");
      tally_and_finish();
   end
endmodule
